// [pit_pkg.sv]
// package: constants and types for the programmed input transfer sequencer
package pit_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int MEM_CYCLE_NS = 750;
    localparam int SLOTS_PER_CYCLE = 15;
    // clocks in one memory cycle and in one T slot
    localparam int CYCLE_CLKS = MEM_CYCLE_NS / CLK_PERIOD_NS;
    localparam int SLOT_CLKS = CYCLE_CLKS / SLOTS_PER_CYCLE;
    localparam logic [3:0] SLOT_HOLD_START = 4'h3;
    localparam logic [3:0] SLOT_SYNC = 4'h5;
    localparam logic [3:0] SLOT_HOLD_END = 4'hD;
    localparam logic [3:0] SLOT_LAST = 4'hF;
    // ------------------------------------------------------------
    // instruction word fields
    // ------------------------------------------------------------
    localparam int WAIT_BIT = 9;
    localparam int UNIT_LSB = 10;
    localparam int UNIT_W = 6;
    localparam int WORD_W = 16;
    localparam logic ODD_PARITY_DEFAULT = 1'b1;
    localparam logic [15:0] PC_RESET = 16'h0000;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_INDIRECT, ST_TEST, ST_EXEC
    } seq_state_e;
    typedef struct packed {
        logic xfer_enable;
        logic wait_flag;
        logic [UNIT_W-1:0] unit_number;
        logic instr_sync;
        logic data_accepted;
        logic parity_error;
    } bus_out_s;
    typedef struct packed {
        logic unit_test_return;
        logic unit_sync_return;
        logic parity_request;
        logic parity_bit;
        logic [WORD_W-1:0] data;
    } bus_in_s;
endpackage

// [pit_sync3.sv]
// file: three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pit_sync3 #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg, out_reg;
    logic [W-1:0] out_next;

    // a bit changes only once stages two and three agree
    always_comb begin
        out_next = out_reg;
        for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                out_next[i] = s2_reg[i];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            out_reg <= '0;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign dout = out_reg;
endmodule // pit_sync3

// [pit_input_seq.sv]
// file: mainframe sequencer for programmed single-word input transfers
// Summary of operation
// - input instruction: at least two fetch cycles then one execute
// - second fetch cycle tests the unit and repeats in wait mode
// - memory input in address mode adds cycles for each extra indirect
// - execute only after address resolved and unit sync returned
// - skip and immediate with ready unit completes in three cycles
// - enable, wait flag and unit held from T3 to next T13
// - instruction sync raised at slot five; only matching unit answers
// - sync sets a hold latch; unit sync return clears it
// - test return advances program counter by two, else by one
// - data accepted takes the word after a ready response
// - a parity bit accompanies every word sent to a unit
// - computer checks input parity on load, flags error to unit
// - wait flag in bit nine, unit number in bits ten to fifteen
`timescale 1ns/1ps
module pit_input_seq
    import pit_pkg::*;
#(
    parameter logic ODD_PARITY = pit_pkg::ODD_PARITY_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic [pit_pkg::WORD_W-1:0] instr_word,
    input wire logic to_memory,
    input wire logic indirect_mode,
    input wire logic [3:0] indirect_depth,
    input wire logic [pit_pkg::WORD_W-1:0] out_word,
    input wire pit_pkg::bus_in_s bus_in,
    output pit_pkg::bus_out_s bus_out,
    output logic out_parity,
    output logic [pit_pkg::WORD_W-1:0] load_data,
    output logic load_strobe,
    output logic load_to_memory,
    output logic [15:0] program_counter,
    output logic busy
);
    import pit_pkg::*;

    // ------------------------------------------------------------
    // bus input synchronisation
    // ------------------------------------------------------------
    localparam int BIN_W = $bits(bus_in_s);
    logic [BIN_W-1:0] bin_sync;
    bus_in_s bin;

    pit_sync3 #(.W(BIN_W)) u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .din(bus_in),
        .dout(bin_sync)
    );
    assign bin = bus_in_s'(bin_sync);

    // ------------------------------------------------------------
    // slot timing and sequencer
    // ------------------------------------------------------------
    seq_state_e state_reg, state_next;
    logic [7:0] clk_cnt_reg, clk_cnt_next;
    logic [3:0] slot_reg, slot_next;
    logic [3:0] ind_left_reg, ind_left_next;
    logic hold_latch_reg, hold_latch_next;
    logic skip_reg, skip_next;
    logic wait_reg, wait_next;
    logic [UNIT_W-1:0] unit_reg, unit_next;
    logic enable_reg, enable_next;
    logic sync_reg, sync_next;
    logic accept_reg, accept_next;
    logic perr_reg, perr_next;
    logic mem_reg, mem_next;
    logic [15:0] pc_reg, pc_next;
    logic [WORD_W-1:0] ld_data_reg, ld_data_next;
    logic ld_stb_reg, ld_stb_next;
    logic opar_reg, opar_next;
    logic busy_reg, busy_next;
    logic slot_tick, cycle_end;

    assign slot_tick = (clk_cnt_reg == 8'(SLOT_CLKS - 1));
    assign cycle_end = slot_tick && (slot_reg == SLOT_LAST);

    // next-state for sequencer, bus drive and program counter
    always_comb begin
        state_next = state_reg;
        clk_cnt_next = slot_tick ? 8'h00 : clk_cnt_reg + 8'h01;
        slot_next = slot_reg;
        ind_left_next = ind_left_reg;
        hold_latch_next = hold_latch_reg;
        skip_next = skip_reg;
        wait_next = wait_reg;
        unit_next = unit_reg;
        enable_next = enable_reg;
        sync_next = sync_reg;
        accept_next = accept_reg;
        perr_next = perr_reg;
        mem_next = mem_reg;
        pc_next = pc_reg;
        ld_data_next = ld_data_reg;
        ld_stb_next = 1'b0;
        // parity bit sent with each outgoing word
        opar_next = (^out_word) ^ ODD_PARITY;
        if (slot_tick) begin
            slot_next = (slot_reg == SLOT_LAST) ? 4'h1 : slot_reg + 4'h1;
        end
        // enables dropped after T13 of the idle cycle that follows execute
        if (state_reg == ST_IDLE && slot_tick &&
            slot_reg == SLOT_HOLD_END) begin
            enable_next = 1'b0;
        end
        case (state_reg)
            ST_IDLE: begin
                if (start && slot_tick && slot_reg == SLOT_LAST) begin
                    state_next = ST_FETCH;
                    mem_next = to_memory;
                    ind_left_next = (to_memory && indirect_mode &&
                        indirect_depth > 4'h1) ? indirect_depth - 4'h1 : 4'h0;
                    perr_next = 1'b0;
                    skip_next = 1'b0;
                end
            end
            ST_FETCH: begin
                // latch instruction fields at T3
                if (slot_tick && slot_reg == (SLOT_HOLD_START - 4'h1)) begin
                    enable_next = 1'b1;
                    wait_next = instr_word[WAIT_BIT];
                    unit_next = instr_word[UNIT_LSB +: UNIT_W];
                end
                // instruction sync at the sync slot sets the hold latch
                if (slot_tick && slot_reg == (SLOT_SYNC - 4'h1)) begin
                    sync_next = 1'b1;
                    hold_latch_next = 1'b1;
                end
                if (cycle_end) begin
                    state_next = (ind_left_reg != 4'h0) ? ST_INDIRECT
                        : ST_TEST;
                end
            end
            ST_INDIRECT: begin
                if (cycle_end) begin
                    ind_left_next = ind_left_reg - 4'h1;
                    if (ind_left_reg == 4'h1) begin
                        state_next = ST_TEST;
                    end
                end
            end
            ST_TEST: begin
                // sync return clears the hold latch, test return notes skip
                if (bin.unit_sync_return && hold_latch_reg) begin
                    hold_latch_next = 1'b0;
                    skip_next = bin.unit_test_return;
                end
                if (cycle_end && !hold_latch_next) begin
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (skip_reg && slot_tick && slot_reg == SLOT_SYNC) begin
                    accept_next = 1'b1;
                    ld_data_next = bin.data;
                    ld_stb_next = 1'b1;
                    // check parity while loading
                    if (((^bin.data) ^ bin.parity_bit) != ODD_PARITY) begin
                        perr_next = bin.parity_request;
                    end
                end
                // data accepted stands through slots six to thirteen
                if (slot_tick && slot_reg == SLOT_HOLD_END) begin
                    accept_next = 1'b0;
                end
                if (cycle_end) begin
                    sync_next = 1'b0;
                    pc_next = pc_reg +
                        (skip_reg ? 16'h0002 : 16'h0001);
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        // busy comes from a flip-flop, in step with the state register
        busy_next = (state_next != ST_IDLE);
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            clk_cnt_reg <= 8'h00;
            slot_reg <= 4'h1;
            ind_left_reg <= 4'h0;
            hold_latch_reg <= 1'b0;
            skip_reg <= 1'b0;
            wait_reg <= 1'b0;
            unit_reg <= '0;
            enable_reg <= 1'b0;
            sync_reg <= 1'b0;
            accept_reg <= 1'b0;
            perr_reg <= 1'b0;
            mem_reg <= 1'b0;
            pc_reg <= PC_RESET;
            ld_data_reg <= '0;
            ld_stb_reg <= 1'b0;
            opar_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            clk_cnt_reg <= clk_cnt_next;
            slot_reg <= slot_next;
            ind_left_reg <= ind_left_next;
            hold_latch_reg <= hold_latch_next;
            skip_reg <= skip_next;
            wait_reg <= wait_next;
            unit_reg <= unit_next;
            enable_reg <= enable_next;
            sync_reg <= sync_next;
            accept_reg <= accept_next;
            perr_reg <= perr_next;
            mem_reg <= mem_next;
            pc_reg <= pc_next;
            ld_data_reg <= ld_data_next;
            ld_stb_reg <= ld_stb_next;
            opar_reg <= opar_next;
            busy_reg <= busy_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus_out = '{xfer_enable: enable_reg, wait_flag: wait_reg,
        unit_number: unit_reg, instr_sync: sync_reg,
        data_accepted: accept_reg, parity_error: perr_reg};
    assign out_parity = opar_reg;
    assign load_data = ld_data_reg;
    assign load_strobe = ld_stb_reg;
    assign load_to_memory = mem_reg;
    assign program_counter = pc_reg;
    assign busy = busy_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_exec_after_test: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        (state_next == ST_EXEC && state_reg != ST_EXEC) |->
        state_reg == ST_TEST)
        else $error("execute entered without test cycle");
    a_hold_blocks: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        (state_reg == ST_TEST && hold_latch_reg && !bin.unit_sync_return)
        |=> state_reg == ST_TEST)
        else $error("left test cycle while held");
    a_sync_sets_hold: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        $rose(sync_reg) |-> hold_latch_reg)
        else $error("sync without hold latch");
    a_sync_slot: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        $rose(sync_reg) |-> slot_reg == SLOT_SYNC)
        else $error("sync not at slot five");
    a_pc_step: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        (state_reg == ST_EXEC && cycle_end) |=>
        pc_reg == $past(pc_reg) + ($past(skip_reg) ? 16'h0002 : 16'h0001))
        else $error("program counter step wrong");
    a_enable_held: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        (state_reg == ST_TEST) |-> enable_reg && $stable(unit_reg))
        else $error("enable or unit not held");
    a_accept_ready: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        $rose(accept_reg) |-> skip_reg && state_reg == ST_EXEC)
        else $error("data accepted without ready");
    a_indirect_exit: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        (state_reg == ST_INDIRECT && state_next == ST_TEST) |->
        ind_left_reg == 4'h1)
        else $error("indirect chain cut short");
endmodule // pit_input_seq

// [pit_unit_model.sv]
// peripheral controller model answering programmed input transfers
`timescale 1ns/1ps
module pit_unit_model
    import pit_pkg::*;
#(
    parameter logic [5:0] UNIT = 6'h05
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire pit_pkg::bus_out_s bus_out,
    input wire logic buffer_ready,
    input wire logic [15:0] word,
    input wire logic bad_parity,
    output pit_pkg::bus_in_s bus_in
);
    import pit_pkg::*;
    logic test_reg, sync_reg, gate_reg, answered_reg;
    logic selected;
    // ------------------------------------------------------------
    // return flip-flops
    // ------------------------------------------------------------
    // only the addressed unit sees the gated clock
    assign selected = bus_out.instr_sync && bus_out.xfer_enable
        && (bus_out.unit_number == UNIT);
    // one answer per instruction sync
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            test_reg <= 1'b0;
            sync_reg <= 1'b0;
            gate_reg <= 1'b0;
            answered_reg <= 1'b0;
        end else if (!bus_out.instr_sync) begin
            test_reg <= 1'b0;
            sync_reg <= 1'b0;
            answered_reg <= 1'b0;
        end else begin
            if (selected && !answered_reg) begin
                if (buffer_ready) begin
                    test_reg <= 1'b1;
                    sync_reg <= 1'b1;
                    gate_reg <= 1'b1;
                    answered_reg <= 1'b1;
                end else if (!bus_out.wait_flag) begin
                    sync_reg <= 1'b1;
                    answered_reg <= 1'b1;
                end
            end
            if (bus_out.data_accepted) begin
                sync_reg <= 1'b0;
                gate_reg <= 1'b0;
            end
        end
    end
    // data lines show the inverted word while not gated
    always_comb begin
        bus_in.unit_test_return = test_reg;
        bus_in.unit_sync_return = sync_reg;
        bus_in.parity_request = gate_reg;
        bus_in.data = gate_reg ? word : ~word;
        bus_in.parity_bit = (~^word) ^ bad_parity;
    end
endmodule // pit_unit_model

// [programmed_input_transfer_handshake_test.sv]
// self-checking bench for the programmed input transfer sequencer
`timescale 1ns/1ps
module programmed_input_transfer_handshake_test;
    import pit_pkg::*;
    localparam logic [5:0] UNIT = 6'h2A;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic start = 1'b0;
    logic to_memory = 1'b0;
    logic indirect_mode = 1'b0;
    logic [3:0] indirect_depth = 4'h0;
    logic [15:0] instr_word = 16'h0000;
    logic [15:0] out_word = 16'h0000;
    logic [15:0] dev_word = 16'hA5C3;
    logic [15:0] pc_exp = 16'h0000;
    logic buffer_ready = 1'b0;
    logic bad_parity = 1'b0;
    bus_in_s bus_in;
    bus_out_s bus_out;
    logic out_parity, load_strobe, load_to_memory, busy;
    logic [15:0] load_data, program_counter;
    int num_errors = 0;
    int samples_checked = 0;
    int strobes = 0;
    int accepts = 0;
    int busy_clks = 0;
    // ------------------------------------------------------------
    // clock, design and partner
    // ------------------------------------------------------------
    always #12.5 sys_clk = ~sys_clk;
    pit_input_seq u_pit_input_seq (.sys_clk(sys_clk), .resetn(resetn),
        .start(start), .instr_word(instr_word), .to_memory(to_memory),
        .indirect_mode(indirect_mode), .indirect_depth(indirect_depth),
        .out_word(out_word), .bus_in(bus_in), .bus_out(bus_out),
        .out_parity(out_parity), .load_data(load_data),
        .load_strobe(load_strobe), .load_to_memory(load_to_memory),
        .program_counter(program_counter), .busy(busy));
    pit_unit_model #(.UNIT(UNIT)) u_pit_unit_model (.sys_clk(sys_clk),
        .resetn(resetn), .bus_out(bus_out), .buffer_ready(buffer_ready),
        .word(dev_word), .bad_parity(bad_parity), .bus_in(bus_in));
    // counts strobes, accept cycles and busy cycles
    always @(posedge sys_clk) begin
        if (load_strobe === 1'b1) strobes <= strobes + 1;
        if (bus_out.data_accepted === 1'b1) accepts <= accepts + 1;
        if (busy === 1'b1) busy_clks <= busy_clks + 1;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask
    task automatic complete_run();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // issues one instruction and waits for it to finish
    task automatic run_instr(input logic wt, input logic mem,
        input logic [3:0] depth);
        int n;
        @(negedge sys_clk);
        instr_word = {UNIT, wt, 9'h000};
        to_memory = mem;
        indirect_mode = (depth != 4'h0);
        indirect_depth = depth;
        strobes = 0;
        accepts = 0;
        busy_clks = 0;
        start = 1'b1;
        n = 0;
        while (busy !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        start = 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 5000) begin
            @(negedge sys_clk);
            n++;
        end
        check(n >= 5000, 0);
        repeat (2) @(negedge sys_clk);
        check({bus_out.xfer_enable, bus_out.wait_flag}, {1'b1, wt});
        check(bus_out.unit_number, UNIT);
        check(bus_out.instr_sync, 1'b0);
    endtask
    // common checks of a ready transfer
    task automatic check_ready(input logic mem);
        pc_exp = pc_exp + 16'h0002;
        check(program_counter, pc_exp);
        check(load_data, dev_word);
        check(strobes, 1);
        check(accepts > 0, 1);
        check(load_to_memory, mem);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic scen_ready_wait();
        buffer_ready = 1'b1;
        dev_word = 16'hA5C3;
        run_instr(1'b1, 1'b0, 4'h0);
        check_ready(1'b0);
        check(busy_clks >= 90 && busy_clks <= 120, 1);
        check(bus_out.parity_error, 1'b0);
    endtask
    task automatic scen_skip_not_ready();
        buffer_ready = 1'b0;
        run_instr(1'b0, 1'b0, 4'h0);
        pc_exp = pc_exp + 16'h0001;
        check(program_counter, pc_exp);
        check(strobes, 0);
        check(accepts, 0);
    endtask
    task automatic scen_wait_late_ready();
        buffer_ready = 1'b0;
        dev_word = 16'h0001;
        fork
            run_instr(1'b1, 1'b0, 4'h0);
            begin
                repeat (300) @(negedge sys_clk);
                buffer_ready = 1'b1;
            end
        join
        check(busy_clks >= 300, 1);
        check_ready(1'b0);
    endtask
    task automatic scen_memory_chain();
        logic [3:0] depth;
        buffer_ready = 1'b1;
        for (int i = 0; i < 2; i++) begin
            depth = (i == 0) ? 4'h1 : 4'h3;
            dev_word = 16'hFFFE - 16'(i);
            run_instr(1'b0, 1'b1, depth);
            check_ready(1'b1);
            check(busy_clks >= 60 + 30 * depth, 1);
            check(busy_clks <= 90 + 30 * depth, 1);
        end
    endtask
    task automatic scen_parity();
        buffer_ready = 1'b1;
        bad_parity = 1'b1;
        run_instr(1'b1, 1'b0, 4'h0);
        check_ready(1'b0);
        check(bus_out.parity_error, 1'b1);
        bad_parity = 1'b0;
        run_instr(1'b0, 1'b0, 4'h0);
        check_ready(1'b0);
        check(bus_out.parity_error, 1'b0);
        for (int i = 0; i < 4; i++) begin
            out_word = 16'h0001 << (i * 5) | 16'(i);
            repeat (2) @(negedge sys_clk);
            check(out_parity, ~^out_word);
            check((^out_word) ^ out_parity, 1'b1);
        end
    endtask
    // watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        complete_run();
    end
    // main sequence
    initial begin
        repeat (5) @(negedge sys_clk);
        resetn = 1'b1;
        check({busy, program_counter}, 17'h0_0000);
        scen_ready_wait();
        scen_skip_not_ready();
        scen_wait_late_ready();
        scen_memory_chain();
        scen_parity();
        complete_run();
    end
endmodule // programmed_input_transfer_handshake_test
